/* cegn_map.vh */
// constants of the clock enable and internal clock generator block
// assumes a 10 MHz system clock and a 32-bit AXI4-Lite register port
`ifndef CEGN_MAP_VH
`define CEGN_MAP_VH

// register byte offsets
`define CEGN_OFS_CTRL 8'h00
`define CEGN_OFS_CONF 8'h04
`define CEGN_OFS_MULT 8'h08
`define CEGN_OFS_STAT 8'h0C
`define CEGN_OFS_CODE 8'h10

// control register fields
`define CEGN_CTRL_INT_ON 0
`define CEGN_CTRL_EXT_ON 1
`define CEGN_CTRL_BUS_EXT 2
`define CEGN_CTRL_RST 3'h0

// configuration register fields
`define CEGN_CONF_EXT_ALLOWED 0
`define CEGN_CONF_CRYSTAL 1
`define CEGN_CONF_IN_STOP 2
`define CEGN_CONF_RST 3'h0

// status register fields
`define CEGN_STAT_INT_EN 0
`define CEGN_STAT_EXT_EN 1
`define CEGN_STAT_STABLE 2
`define CEGN_STAT_PORT_A 3
`define CEGN_STAT_PORT_B 4
`define CEGN_STAT_STOP 5

// multiplier and oscillator code
`define CEGN_MULT_RST 7'h01
`define CEGN_CODE_RST 12'h780
`define CEGN_CODE_MAX 12'h9FF
`define CEGN_CODE_TOP 12'hFFF
`define CEGN_DIVCTL_SLOWEST 4'h9

// timing: nominal base frequency against the system clock
`define CEGN_CLK_FREQ_HZ 10000000
`define CEGN_NOM_FREQ_HZ 307200
`define CEGN_NOM_CYCLES (`CEGN_CLK_FREQ_HZ / `CEGN_NOM_FREQ_HZ)

// frequency error bands in percent, and correction steps
`define CEGN_BAND_LOW_WIDE 85
`define CEGN_BAND_LOW_NEAR 95
`define CEGN_BAND_HIGH_NEAR 105
`define CEGN_BAND_HIGH_WIDE 115
`define CEGN_STEP_WIDE 12'h020
`define CEGN_STEP_MID 12'h008
`define CEGN_STEP_FINE 12'h001

// controlled oscillator model: period = min + (code >> shift)
`define CEGN_OSC_MIN_PERIOD 8'h02
`define CEGN_OSC_SHIFT 6

// axi responses
`define CEGN_RESP_OKAY 2'b00
`define CEGN_RESP_SLVERR 2'b10

`endif

/* cegn_dco.v */
// controlled oscillator: one-cycle tick whose spacing follows the 12-bit code
// assumes enable comes from the clock enable logic; code is held by the loop filter
`timescale 1ns/1ps
`include "cegn_map.vh"

module cegn_ctrl_osc (
  input wire clk,
  input wire resetn,
  input wire enable,
  input wire [11:0] code,
  output reg tick
);

  reg [7:0] count;
  wire [11:0] effCode;
  wire [7:0] period;

  // divider codes above nine behave as the slowest setting
  assign effCode = (code[11:8] > `CEGN_DIVCTL_SLOWEST) ? {`CEGN_DIVCTL_SLOWEST, code[7:0]} : code; // R18
  assign period = `CEGN_OSC_MIN_PERIOD + effCode[11:`CEGN_OSC_SHIFT]; // R11

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= 8'h00;
      tick <= 1'b0;
    end else if (!enable) begin
      count <= 8'h00;
      tick <= 1'b0; // R05
    end else if (count >= period - 8'h01) begin
      count <= 8'h00;
      tick <= 1'b1;
    end else begin
      count <= count + 8'h01;
      tick <= 1'b0;
    end
  end

endmodule // cegn_ctrl_osc

/* cegn_modn.v */
// modulo N divider: turns the fast tick into the base tick
// assumes inTick is a one-cycle pulse; N of zero or one passes it straight
`timescale 1ns/1ps
`include "cegn_map.vh"

module cegn_modn #(
  parameter WIDTH = 7
) (
  input wire clk,
  input wire resetn,
  input wire enable,
  input wire [WIDTH-1:0] factor,
  input wire inTick,
  output reg outTick
);

  reg [WIDTH-1:0] count;
  wire bypass;

  assign bypass = (factor <= {{(WIDTH-1){1'b0}}, 1'b1}); // R13

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= {WIDTH{1'b0}};
      outTick <= 1'b0;
    end else if (!enable) begin
      count <= {WIDTH{1'b0}};
      outTick <= 1'b0; // R05
    end else if (bypass) begin
      count <= {WIDTH{1'b0}};
      outTick <= inTick; // R13
    end else if (inTick) begin
      if (count >= factor - {{(WIDTH-1){1'b0}}, 1'b1}) begin
        count <= {WIDTH{1'b0}};
        outTick <= 1'b1; // R12
      end else begin
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        outTick <= 1'b0;
      end
    end else begin
      outTick <= 1'b0;
    end
  end

endmodule // cegn_modn

/* cegn_clock_enable.v */
// clock enable logic, internal clock generator loop and clock outputs
// assumes one 10 MHz clock; every generated clock is a one-cycle enable pulse
// assumes the stop request and the oscillator pin are synchronous to clk
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "cegn_map.vh"

//////////////////////////////////////////////////////////////////////////////
// Contract
// R01: bus rate is oscillator/4 and generator/2
// R02: stop without keep-bit asserts stop, halting clocks
// R03: keep-bit set keeps clocks running in stop
// R04: internal enable equals on-bit and not stop
// R05: internal disabled holds fast and base clocks low
// R06: external enable is on-bit and not stop
// R07: external on-bit settable only when allowed
// R08: pin A port enable is inverse on-bit
// R09: pin B port off when on-bit and crystal
// R10: base nominal, fast is N times base
// R11: oscillator period set by 12-bit code
// R12: divider makes base from fast by N
// R13: N of zero or one bypasses divider
// R14: comparator checks base against nominal, feeds filter
// R15: timebase uses external clock when available
// R16: software selects bus clock source
// R17: filter steps code by error-sized correction
// R18: divider codes above nine act as nine
// R19: error within five percent sets stable flag
// R20: leaving stop releases stop, enables follow bits
module cegn_clock_enable #(
  parameter ADDR_WIDTH = 8,
  parameter MULT_WIDTH = 7
) (
  input wire clk,
  input wire resetn,
  input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire stopMode,
  input wire extClockPin,
  output wire moduleStopSignal,
  output wire internalGeneratorEnable,
  output wire externalGeneratorEnable,
  output wire portPinAEnable,
  output wire portPinBEnable,
  output wire internalFastClock,
  output wire baseClock,
  output reg externalClockOut,
  output reg oscillatorOutputClock,
  output reg generatorOutputClock,
  output reg busClockEnable,
  output reg timebaseClock,
  output reg filterStableFlag
);

  //////////////////////////////////////////////////////////////////////////////
  // registers

  reg internalGeneratorOnBit;
  reg externalGeneratorOnBit;
  reg busSourceExternal;
  reg externalClockAllowedConfig;
  reg crystalEnableConfig;
  reg clocksInStopConfig;
  reg [MULT_WIDTH-1:0] multiplierRegister;
  reg [11:0] oscillatorCode;
  localparam [2:0] CTRL_RESET = `CEGN_CTRL_RST;

  function [2:0] regIndex;
    input [ADDR_WIDTH-1:0] addr;
    begin
      case (addr)
        `CEGN_OFS_CTRL: regIndex = 3'd1;
        `CEGN_OFS_CONF: regIndex = 3'd2;
        `CEGN_OFS_MULT: regIndex = 3'd3;
        `CEGN_OFS_STAT: regIndex = 3'd4;
        `CEGN_OFS_CODE: regIndex = 3'd5;
        default: regIndex = 3'd0;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // clock enable circuit

  assign moduleStopSignal = stopMode & ~clocksInStopConfig; // R02 R03 R20
  assign internalGeneratorEnable = internalGeneratorOnBit & ~moduleStopSignal; // R04
  assign externalGeneratorEnable = externalGeneratorOnBit & ~moduleStopSignal; // R06
  // the port enables ignore stop so the oscillator pins stay claimed while stopped
  assign portPinAEnable = ~externalGeneratorOnBit; // R08
  assign portPinBEnable = ~(externalGeneratorOnBit & crystalEnableConfig); // R09

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path

  reg awTaken;
  reg wTaken;
  reg [ADDR_WIDTH-1:0] awAddrHeld;
  reg [31:0] wDataHeld;
  reg [3:0] wStrbHeld;
  wire writeGo;

  assign s_axi_awready = ~awTaken & ~s_axi_bvalid;
  assign s_axi_wready = ~wTaken & ~s_axi_bvalid;
  assign writeGo = awTaken & wTaken & ~s_axi_bvalid;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awTaken <= 1'b0;
      wTaken <= 1'b0;
      awAddrHeld <= {ADDR_WIDTH{1'b0}};
      wDataHeld <= 32'h0000_0000;
      wStrbHeld <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CEGN_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awTaken <= 1'b1;
        awAddrHeld <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wTaken <= 1'b1;
        wDataHeld <= s_axi_wdata;
        wStrbHeld <= s_axi_wstrb;
      end
      if (writeGo) begin
        awTaken <= 1'b0;
        wTaken <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (regIndex(awAddrHeld) == 3'd0) ? `CEGN_RESP_SLVERR : `CEGN_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // only byte lane 0 carries register bits
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      internalGeneratorOnBit <= CTRL_RESET[`CEGN_CTRL_INT_ON];
      externalGeneratorOnBit <= 1'b0;
      busSourceExternal <= 1'b0;
      externalClockAllowedConfig <= 1'b0;
      crystalEnableConfig <= 1'b0;
      clocksInStopConfig <= 1'b0;
      multiplierRegister <= `CEGN_MULT_RST;
    end else if (writeGo && wStrbHeld[0]) begin
      case (regIndex(awAddrHeld))
        3'd1: begin
          internalGeneratorOnBit <= wDataHeld[`CEGN_CTRL_INT_ON];
          externalGeneratorOnBit <= wDataHeld[`CEGN_CTRL_EXT_ON] & externalClockAllowedConfig; // R07
          busSourceExternal <= wDataHeld[`CEGN_CTRL_BUS_EXT]; // R16
        end
        3'd2: begin
          externalClockAllowedConfig <= wDataHeld[`CEGN_CONF_EXT_ALLOWED];
          crystalEnableConfig <= wDataHeld[`CEGN_CONF_CRYSTAL];
          clocksInStopConfig <= wDataHeld[`CEGN_CONF_IN_STOP];
        end
        3'd3: begin
          multiplierRegister <= wDataHeld[MULT_WIDTH-1:0]; // R10
        end
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path

  reg [31:0] readValue;

  assign s_axi_arready = ~s_axi_rvalid;

  always @* begin
    readValue = 32'h0000_0000;
    case (regIndex(s_axi_araddr))
      3'd1: begin
        readValue[`CEGN_CTRL_INT_ON] = internalGeneratorOnBit;
        readValue[`CEGN_CTRL_EXT_ON] = externalGeneratorOnBit;
        readValue[`CEGN_CTRL_BUS_EXT] = busSourceExternal;
      end
      3'd2: begin
        readValue[`CEGN_CONF_EXT_ALLOWED] = externalClockAllowedConfig;
        readValue[`CEGN_CONF_CRYSTAL] = crystalEnableConfig;
        readValue[`CEGN_CONF_IN_STOP] = clocksInStopConfig;
      end
      3'd3: readValue[MULT_WIDTH-1:0] = multiplierRegister;
      3'd4: begin
        readValue[`CEGN_STAT_INT_EN] = internalGeneratorEnable;
        readValue[`CEGN_STAT_EXT_EN] = externalGeneratorEnable;
        readValue[`CEGN_STAT_STABLE] = filterStableFlag;
        readValue[`CEGN_STAT_PORT_A] = portPinAEnable;
        readValue[`CEGN_STAT_PORT_B] = portPinBEnable;
        readValue[`CEGN_STAT_STOP] = moduleStopSignal;
      end
      3'd5: readValue[11:0] = oscillatorCode;
      default: readValue = 32'h0000_0000;
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CEGN_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readValue;
      s_axi_rresp <= (regIndex(s_axi_araddr) == 3'd0) ? `CEGN_RESP_SLVERR : `CEGN_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // internal generator: oscillator and modulo N divider

  cegn_ctrl_osc cegn_ctrl_osc_inst (
    .clk(clk),
    .resetn(resetn),
    .enable(internalGeneratorEnable),
    .code(oscillatorCode),
    .tick(internalFastClock)
  );

  cegn_modn #(
    .WIDTH(MULT_WIDTH)
  ) cegn_modn_inst (
    .clk(clk),
    .resetn(resetn),
    .enable(internalGeneratorEnable),
    .factor(multiplierRegister),
    .inTick(internalFastClock),
    .outTick(baseClock)
  );

  //////////////////////////////////////////////////////////////////////////////
  // frequency comparator and loop filter

  reg [15:0] periodCount;
  reg periodValid;
  wire [15:0] period;
  wire [23:0] scaledPeriod;
  wire [23:0] nomScaled;
  wire [31:0] nomFull;
  reg [11:0] nextCode;
  reg nextStable;

  // the base period in system cycles stands in for the voltage comparison
  assign period = periodCount + 16'h0001;
  assign scaledPeriod = {8'h00, period};
  assign nomFull = (`CEGN_NOM_CYCLES) * 100;
  assign nomScaled = nomFull[23:0];

  // frequency ratio nom/period against each band edge; a longer period means a slow base clock
  always @* begin
    nextCode = oscillatorCode;
    nextStable = 1'b0;
    if (nomScaled < scaledPeriod * `CEGN_BAND_LOW_WIDE) begin
      nextCode = (oscillatorCode < `CEGN_STEP_WIDE) ? 12'h000 : oscillatorCode - `CEGN_STEP_WIDE; // R17
    end else if (nomScaled < scaledPeriod * `CEGN_BAND_LOW_NEAR) begin
      nextCode = (oscillatorCode < `CEGN_STEP_MID) ? 12'h000 : oscillatorCode - `CEGN_STEP_MID; // R17
    end else if (nomScaled < scaledPeriod * 100) begin
      nextCode = (oscillatorCode < `CEGN_STEP_FINE) ? 12'h000 : oscillatorCode - `CEGN_STEP_FINE; // R17
      nextStable = 1'b1; // R19
    end else if (nomScaled == scaledPeriod * 100) begin
      nextStable = 1'b1; // R19
    end else if (nomScaled < scaledPeriod * `CEGN_BAND_HIGH_NEAR) begin
      nextCode = (oscillatorCode > `CEGN_CODE_TOP - `CEGN_STEP_FINE) ? `CEGN_CODE_TOP :
                 oscillatorCode + `CEGN_STEP_FINE; // R17
      nextStable = 1'b1; // R19
    end else if (nomScaled < scaledPeriod * `CEGN_BAND_HIGH_WIDE) begin
      nextCode = (oscillatorCode > `CEGN_CODE_TOP - `CEGN_STEP_MID) ? `CEGN_CODE_TOP :
                 oscillatorCode + `CEGN_STEP_MID; // R17
    end else begin
      nextCode = (oscillatorCode > `CEGN_CODE_TOP - `CEGN_STEP_WIDE) ? `CEGN_CODE_TOP :
                 oscillatorCode + `CEGN_STEP_WIDE; // R17
    end
  end

  // the code saturates instead of wrapping, so an overshoot past the valid top recovers by stepping down
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      periodCount <= 16'h0000;
      periodValid <= 1'b0;
      oscillatorCode <= `CEGN_CODE_RST;
      filterStableFlag <= 1'b0;
    end else if (!internalGeneratorEnable) begin
      periodCount <= 16'h0000;
      periodValid <= 1'b0;
      filterStableFlag <= 1'b0;
    end else if (baseClock) begin
      periodCount <= 16'h0000;
      periodValid <= 1'b1;
      if (periodValid) begin
        oscillatorCode <= nextCode; // R14
        filterStableFlag <= nextStable; // R19
      end
    end else if (periodCount != 16'hFFFF) begin
      periodCount <= periodCount + 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // external clock path and clock selection

  reg extPinPrev;
  reg [1:0] oscPhase;
  wire sourceTick;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      extPinPrev <= 1'b0;
      externalClockOut <= 1'b0;
    end else begin
      extPinPrev <= extClockPin;
      externalClockOut <= externalGeneratorEnable & extClockPin & ~extPinPrev; // R06
    end
  end

  assign sourceTick = busSourceExternal ? externalClockOut : internalFastClock; // R16

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oscPhase <= 2'b00;
      oscillatorOutputClock <= 1'b0;
      generatorOutputClock <= 1'b0;
      busClockEnable <= 1'b0;
      timebaseClock <= 1'b0;
    end else begin
      oscillatorOutputClock <= sourceTick;
      generatorOutputClock <= sourceTick & oscPhase[0]; // R01
      busClockEnable <= sourceTick & (oscPhase == 2'b11); // R01
      if (sourceTick) begin
        oscPhase <= oscPhase + 2'b01;
      end
      timebaseClock <= externalGeneratorEnable ? externalClockOut : internalFastClock; // R15
    end
  end

endmodule // cegn_clock_enable

/* cegn_clock_enable_sva.sv */
// checker of the clock enable block: enables, gating and generated clocks
// assumes it is bound onto cegn_clock_enable, one clock domain
`timescale 1ns/1ps
module cegn_clock_enable_sva (
  input logic clk,
  input logic resetn,
  input logic stopMode,
  input logic moduleStopSignal,
  input logic internalGeneratorEnable,
  input logic externalGeneratorEnable,
  input logic portPinAEnable,
  input logic portPinBEnable,
  input logic internalFastClock,
  input logic baseClock,
  input logic externalClockOut,
  input logic timebaseClock,
  input logic filterStableFlag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  // two cycles off, so the one-cycle output registers have drained
  sequence intOff;
    !internalGeneratorEnable ##1 !internalGeneratorEnable;
  endsequence
  sequence extOff;
    !externalGeneratorEnable ##1 !externalGeneratorEnable;
  endsequence
  a_stop_gates_enables: assert property (
    moduleStopSignal |-> !internalGeneratorEnable && !externalGeneratorEnable)
    else $error("enable active while stopped");
  a_stop_only_mode: assert property (
    !stopMode |-> !moduleStopSignal) else $error("stop without stop mode");
  a_stop_release: assert property (
    $fell(stopMode) |-> !moduleStopSignal) else $error("stop held after exit");
  a_int_off_low: assert property (
    intOff |-> !internalFastClock && !baseClock) else $error("internal clocks run while off");
  a_ext_off_low: assert property (
    extOff |-> !externalClockOut) else $error("external clock runs while off");
  a_pin_a_inverse: assert property (
    !moduleStopSignal |-> portPinAEnable != externalGeneratorEnable) else $error("pin a enable wrong");
  a_pin_b_needs: assert property (
    !portPinBEnable |-> !portPinAEnable) else $error("pin b off without external");
  a_tb_external: assert property (
    externalGeneratorEnable && externalClockOut |=> timebaseClock) else $error("timebase missed external");
  a_tb_internal: assert property (
    !externalGeneratorEnable && internalFastClock |=> timebaseClock) else $error("timebase missed internal");
  a_stable_cleared: assert property (
    intOff |-> !filterStableFlag) else $error("stable flag while off");
endmodule // cegn_clock_enable_sva

bind cegn_clock_enable cegn_clock_enable_sva cegn_clock_enable_sva_inst (
  .clk, .resetn, .stopMode, .moduleStopSignal, .internalGeneratorEnable, .externalGeneratorEnable,
  .portPinAEnable, .portPinBEnable, .internalFastClock, .baseClock, .externalClockOut, .timebaseClock,
  .filterStableFlag
);

/* cegn_partner.sv */
// model of the oscillator pin and the clock consumers beyond the block
// assumes generated clocks are one-cycle pulses seen on the rising clk edge
`timescale 1ns/1ps
module cegn_partner (
  input logic clk,
  input logic resetn,
  input logic clr,
  input logic [6:0] pulses,
  output logic extClockPin,
  output logic [6:0][15:0] counts
);
  logic [2:0] phase;
  ////////////////////////////////////////
  // oscillator at a sixth of clk, slow enough that every edge is seen
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase <= 3'h0;
      extClockPin <= 1'b0;
    end else begin
      phase <= (phase == 3'h5) ? 3'h0 : phase + 3'h1;
      extClockPin <= (phase < 3'h3);
    end
  end
  ////////////////////////////////////////
  // consumers count pulses; clr opens a new window
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      counts <= '0;
    end else begin
      for (int i = 0; i < 7; i++) begin
        counts[i] <= clr ? 16'h0000 : counts[i] + {15'h0000, pulses[i]};
      end
    end
  end
endmodule // cegn_partner

/* test_cegn_clock_enable.sv */
// self-checking bench of the clock enable and internal clock generator block
// assumes the register map header, the partner model and the bound checker
`timescale 1ns/1ps
`include "cegn_map.vh"
module test_cegn_clock_enable;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  localparam logic [1:0] OK = `CEGN_RESP_OKAY;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, stopMode = 1'b0, clr = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, extClockPin;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire moduleStopSignal, internalGeneratorEnable, externalGeneratorEnable, portPinAEnable, portPinBEnable;
  wire internalFastClock, baseClock, externalClockOut, oscillatorOutputClock, generatorOutputClock;
  wire busClockEnable, timebaseClock, filterStableFlag;
  wire [6:0][15:0] counts;
  int errCount = 0;
  int comparisons = 0;
  always #50 clk = ~clk;
  cegn_clock_enable cegn_clock_enable_inst (
    .clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stopMode, .extClockPin, .moduleStopSignal,
    .internalGeneratorEnable, .externalGeneratorEnable, .portPinAEnable, .portPinBEnable, .internalFastClock,
    .baseClock, .externalClockOut, .oscillatorOutputClock, .generatorOutputClock, .busClockEnable,
    .timebaseClock, .filterStableFlag
  );
  cegn_partner cegn_partner_inst (
    .clk, .resetn, .clr, .extClockPin, .counts,
    .pulses({timebaseClock, busClockEnable, generatorOutputClock, oscillatorOutputClock, externalClockOut,
      baseClock, internalFastClock})
  );
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // pulse counts drift by one at window edges, so rates compare with a tolerance
  function automatic logic near(input int a, input int b, input int tol);
    return (a - b <= tol) && (b - a <= tol);
  endfunction
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check("bresp", er, s_axi_bresp);
  endtask
  task automatic axiRead(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    check("rresp", er, s_axi_rresp);
  endtask
  task automatic regIs(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] d;
    axiRead(a, OK, d);
    check(nm, exp, d);
  endtask
  task automatic measure(input int n);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  ////////////////////////////////////////
  task automatic testReset();
    logic [31:0] d;
    regIs(`CEGN_OFS_CTRL, ZERO, "ctrl reset");
    regIs(`CEGN_OFS_MULT, ONE, "mult reset");
    regIs(`CEGN_OFS_CODE, 32'h0000_0780, "code reset");
    regIs(`CEGN_OFS_STAT, 32'h0000_0018, "stat reset");
    axiWrite(`CEGN_OFS_STAT, 32'h0000_00FF, OK);
    regIs(`CEGN_OFS_STAT, 32'h0000_0018, "stat read only");
    axiWrite(8'h14, ONE, `CEGN_RESP_SLVERR);
    axiRead(8'h14, `CEGN_RESP_SLVERR, d);
    check("unmapped data", ZERO, d);
    $display("test reset done");
  endtask
  task automatic testEnables();
    axiWrite(`CEGN_OFS_CTRL, 32'h0000_0002, OK);
    regIs(`CEGN_OFS_CTRL, ZERO, "ext bit refused");
    axiWrite(`CEGN_OFS_CONF, 32'h0000_0003, OK);
    axiWrite(`CEGN_OFS_CTRL, 32'h0000_0003, OK);
    check("int en", ONE, internalGeneratorEnable);
    check("ext en", ONE, externalGeneratorEnable);
    check("pin a", ZERO, portPinAEnable);
    check("pin b", ZERO, portPinBEnable);
    axiWrite(`CEGN_OFS_CONF, ONE, OK);
    check("pin b no crystal", ONE, portPinBEnable);
    $display("test enables done");
  endtask
  task automatic testStop();
    stopMode <= 1'b1;
    @(posedge clk);
    check("stop sig", ONE, moduleStopSignal);
    check("int en stop", ZERO, internalGeneratorEnable);
    check("pin a stop", ZERO, portPinAEnable);
    measure(100);
    check("fast halted", ZERO, counts[0]);
    check("base halted", ZERO, counts[1]);
    check("ext halted", ZERO, counts[2]);
    stopMode <= 1'b0;
    @(posedge clk);
    check("stop off", ZERO, moduleStopSignal);
    check("ext en back", ONE, externalGeneratorEnable);
    axiWrite(`CEGN_OFS_CONF, 32'h0000_0005, OK);
    stopMode <= 1'b1;
    measure(100);
    check("kept in stop", ONE, internalGeneratorEnable);
    check("fast in stop", ONE, counts[0] > 0);
    stopMode <= 1'b0;
    $display("test stop done");
  endtask
  task automatic testLoop();
    logic [31:0] code;
    axiWrite(`CEGN_OFS_CTRL, ONE, OK);
    measure(400);
    check("stable", ONE, filterStableFlag);
    regIs(`CEGN_OFS_CODE, 32'h0000_0780, "code held");
    axiWrite(`CEGN_OFS_MULT, 32'h0000_0002, OK);
    measure(300);
    check("stable lost", ZERO, filterStableFlag);
    axiRead(`CEGN_OFS_CODE, OK, code);
    check("code steps", ONE, code < 32'h0000_0780 && code[4:0] === 5'h00);
    measure(320);
    check("fast spacing", ONE, near(counts[0], 320 / (2 + (code >> 6)), 2));
    $display("test loop done");
  endtask
  task automatic testDivide();
    logic [31:0] m [3] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0004};
    for (int i = 0; i < 3; i++) begin
      axiWrite(`CEGN_OFS_MULT, m[i], OK);
      measure(640);
      check("base rate", ONE, near(counts[1], counts[0] / (m[i] < 2 ? 1 : m[i]), 1));
    end
    $display("test divide done");
  endtask
  task automatic testRatio();
    axiWrite(`CEGN_OFS_MULT, ONE, OK);
    measure(640);
    check("gen half osc", ONE, near(2 * counts[4], counts[3], 2));
    check("bus half gen", ONE, near(2 * counts[5], counts[4], 2));
    check("tb internal", ONE, near(counts[6], counts[0], 1));
    axiWrite(`CEGN_OFS_CTRL, 32'h0000_0007, OK);
    measure(600);
    check("ext pulses", ONE, near(counts[2], 100, 1));
    check("osc from ext", ONE, near(counts[3], counts[2], 1));
    check("tb external", ONE, near(counts[6], counts[2], 1));
    check("bus quarter", ONE, near(4 * counts[5], counts[3], 4));
    $display("test ratio done");
  endtask
  ////////////////////////////////////////
  task automatic endSim();
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    testReset();
    testEnables();
    testStop();
    testLoop();
    testDivide();
    testRatio();
    endSim();
  end
  // whole run needs some 4500 cycles
  initial begin
    repeat (30000) @(posedge clk);
    errCount++;
    $display("[FAIL] watchdog expected finish seen timeout");
    endSim();
  end
endmodule // test_cegn_clock_enable
